// ### ubf_uart.sv
/*
  Serial port top: APB register slave, transmitter and receiver for
  8-bit frames, sticky event flags with a mask and one interrupt line.
  Assumes an APB master on the system clock and asynchronous line,
  oscillator and timer pin inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ubf_params.svh"
module ubf_uart import ubf_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic serial_rx_pin,
  output var logic serial_tx_pin,
  // timer clock sources
  input wire logic ext_osc_clk,
  input wire logic timer_ext_input,
  // interrupt
  output logic irq
);
  logic frame_length_select, multiproc_check_enable, rx_enable_bit;
  logic rx_ninth_bit;
  logic [1:0] status_r, mask_r, stat_clr, stat_set;
  logic run_r;
  logic [2:0] src_r;
  logic [7:0] baud_reload_value, serial_buffer;
  ubf_timer_cfg_s tcfg;
  ubf_ticks_s ticks;
  ubf_tx_state_e tx_state_r;
  ubf_rx_state_e rx_state_r;
  logic [7:0] tx_shift_r, rx_shift_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic [2:0] rx_sync_r;
  logic rx_lvl_r, rx_lvl_nxt, rx_fall, rx_restart, load_ok, stop_sample;
  logic access, wr, addr_ok, buf_wr;
  logic [7:0] off;
  logic [31:0] rd_mux;

  // apb decode
  assign off = 8'(paddr);
  assign access = psel & penable;
  assign addr_ok = (off == `UBF_OFF_CTRL) || (off == `UBF_OFF_BUF) ||
                   (off == `UBF_OFF_TCFG) || (off == `UBF_OFF_RELOAD) ||
                   (off == `UBF_OFF_STAT) || (off == `UBF_OFF_MASK) ||
                   (off == `UBF_OFF_TXCNT);
  assign wr = access & pwrite & addr_ok;
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign buf_wr = wr && (off == `UBF_OFF_BUF);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      frame_length_select <= 1'b0;
      multiproc_check_enable <= 1'b0;
      rx_enable_bit <= 1'b0;
      run_r <= 1'b0;
      src_r <= `UBF_RST_SRC;
      baud_reload_value <= `UBF_RST_RELOAD;
      mask_r <= 2'h0;
    end else if (wr) begin
      if (off == `UBF_OFF_CTRL) begin
        // only 8-bit framing is built; the select bit is kept for software
        frame_length_select <= pwdata[`UBF_CTRL_FLS];
        multiproc_check_enable <= pwdata[`UBF_CTRL_MCE];
        rx_enable_bit <= pwdata[`UBF_CTRL_REN];
      end
      if (off == `UBF_OFF_TCFG) begin
        run_r <= pwdata[`UBF_TCFG_RUN];
        src_r <= pwdata[`UBF_TCFG_SEL_HI:`UBF_TCFG_SEL_LO];
      end
      if (off == `UBF_OFF_RELOAD) begin
        baud_reload_value <= pwdata[7:0];
      end
      if (off == `UBF_OFF_MASK) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (off)
      `UBF_OFF_CTRL: rd_mux[7:0] = {frame_length_select, 1'b0,
        multiproc_check_enable, rx_enable_bit, 1'b0, rx_ninth_bit,
        status_r[`UBF_ST_TX], status_r[`UBF_ST_RX]};
      `UBF_OFF_BUF: rd_mux[7:0] = serial_buffer;
      `UBF_OFF_TCFG: rd_mux[3:0] = {src_r, run_r};
      `UBF_OFF_RELOAD: rd_mux[7:0] = baud_reload_value;
      `UBF_OFF_STAT: rd_mux[1:0] = status_r;
      `UBF_OFF_MASK: rd_mux[1:0] = mask_r;
      `UBF_OFF_TXCNT: rd_mux[7:0] = ticks.tx_count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so prdata is a flop output
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // status flags: a hardware set wins over a same-cycle software clear
  assign stat_clr = (wr && (off == `UBF_OFF_STAT)) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_r <= 2'h0;
    end else begin
      status_r <= (status_r & ~stat_clr) | stat_set;
    end
  end
  assign irq = |(status_r & mask_r);

  // baud timer
  assign tcfg.run = run_r;
  assign tcfg.src = src_r;
  assign tcfg.reload = baud_reload_value;
  ubf_baud_timer u_timer (
    .clock(clock),
    .resetn(resetn),
    .cfg(tcfg),
    .rx_restart(rx_restart),
    .ext_osc_clk(ext_osc_clk),
    .timer_ext_input(timer_ext_input),
    .ticks(ticks)
  );

  // transmitter; a buffer write while busy is dropped
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_state_r <= UBF_TX_IDLE;
      tx_shift_r <= 8'h00;
      tx_bit_r <= 3'h0;
      serial_tx_pin <= 1'b1;
    end else begin
      unique case (tx_state_r)
        UBF_TX_IDLE: begin
          serial_tx_pin <= 1'b1;
          if (buf_wr) begin
            tx_shift_r <= pwdata[7:0];
            tx_state_r <= UBF_TX_WAIT;
          end
        end
        UBF_TX_WAIT: begin
          if (ticks.tx_bit_tick) begin
            serial_tx_pin <= 1'b0;
            tx_state_r <= UBF_TX_START;
          end
        end
        UBF_TX_START: begin
          if (ticks.tx_bit_tick) begin
            serial_tx_pin <= tx_shift_r[0];
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_bit_r <= 3'h0;
            tx_state_r <= UBF_TX_DATA;
          end
        end
        UBF_TX_DATA: begin
          if (ticks.tx_bit_tick) begin
            if (tx_bit_r == `UBF_LAST_DATA_BIT) begin
              serial_tx_pin <= 1'b1;
              tx_state_r <= UBF_TX_STOP;
            end else begin
              serial_tx_pin <= tx_shift_r[0];
              tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              tx_bit_r <= tx_bit_r + 3'h1;
            end
          end
        end
        UBF_TX_STOP: begin
          if (ticks.tx_bit_tick) begin
            tx_state_r <= UBF_TX_IDLE;
          end
        end
      endcase
    end
  end

  // receiver line settling
  assign rx_lvl_nxt = ubf_settle(rx_sync_r, rx_lvl_r);
  assign rx_fall = rx_lvl_r & ~rx_lvl_nxt;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_sync_r <= `UBF_SYNC_IDLE;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], serial_rx_pin};
      rx_lvl_r <= rx_lvl_nxt;
    end
  end

  assign rx_restart = (rx_state_r == UBF_RX_IDLE) && rx_enable_bit &&
                      rx_fall;
  assign stop_sample = (rx_state_r == UBF_RX_STOP) && ticks.rx_sample_tick;
  // a full buffer blocks the load, so the first byte survives an overrun
  assign load_ok = !status_r[`UBF_ST_RX] &&
                   (!multiproc_check_enable || rx_lvl_r);
  assign stat_set[`UBF_ST_RX] = stop_sample && load_ok;
  assign stat_set[`UBF_ST_TX] = (tx_state_r == UBF_TX_DATA) &&
    ticks.tx_bit_tick && (tx_bit_r == `UBF_LAST_DATA_BIT);

  // receiver; a frame under way finishes even if receive is disabled
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_state_r <= UBF_RX_IDLE;
      rx_shift_r <= 8'h00;
      rx_bit_r <= 3'h0;
    end else begin
      unique case (rx_state_r)
        UBF_RX_IDLE: begin
          if (rx_restart) begin
            rx_state_r <= UBF_RX_START;
          end
        end
        UBF_RX_START: begin
          if (ticks.rx_sample_tick) begin
            // a start bit gone high by mid bit was a glitch
            rx_state_r <= rx_lvl_r ? UBF_RX_IDLE : UBF_RX_DATA;
            rx_bit_r <= 3'h0;
          end
        end
        UBF_RX_DATA: begin
          if (ticks.rx_sample_tick) begin
            rx_shift_r <= {rx_lvl_r, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == `UBF_LAST_DATA_BIT) begin
              rx_state_r <= UBF_RX_STOP;
            end
          end
        end
        UBF_RX_STOP: begin
          if (ticks.rx_sample_tick) begin
            rx_state_r <= UBF_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_buffer <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else if (stop_sample && load_ok) begin
      serial_buffer <= rx_shift_r;
      rx_ninth_bit <= rx_lvl_r;
    end
  end

  a_tx_idle_high: assert property (@(posedge clock) disable iff (!resetn)
    tx_state_r == UBF_TX_IDLE && $past(tx_state_r) == UBF_TX_IDLE
    |-> serial_tx_pin)
    else $error("tx line not high while idle");
  a_tx_write_start: assert property (@(posedge clock) disable iff (!resetn)
    buf_wr && tx_state_r == UBF_TX_IDLE |=> tx_state_r == UBF_TX_WAIT &&
    tx_shift_r == $past(pwdata[7:0]))
    else $error("buffer write did not start a frame");
  a_tx_done_stop: assert property (@(posedge clock) disable iff (!resetn)
    $rose(tx_state_r == UBF_TX_STOP) |-> status_r[`UBF_ST_TX] &&
    serial_tx_pin)
    else $error("tx done not set at stop bit start");
  a_rx_enable_gate: assert property (@(posedge clock) disable iff (!resetn)
    !rx_enable_bit && rx_state_r == UBF_RX_IDLE
    |=> rx_state_r == UBF_RX_IDLE)
    else $error("receiver left idle while disabled");
  a_rx_load_ok: assert property (@(posedge clock) disable iff (!resetn)
    stop_sample && load_ok |=> status_r[`UBF_ST_RX] &&
    serial_buffer == $past(rx_shift_r) &&
    rx_ninth_bit == $past(rx_lvl_r))
    else $error("accepted frame not loaded");
  a_rx_load_block: assert property (@(posedge clock) disable iff (!resetn)
    stop_sample && !load_ok |=> $stable(serial_buffer) &&
    $stable(rx_ninth_bit))
    else $error("rejected frame changed the buffer");
  a_rx_mce_stop: assert property (@(posedge clock) disable iff (!resetn)
    stop_sample && multiproc_check_enable && !rx_lvl_r
    |=> !$rose(status_r[`UBF_ST_RX]))
    else $error("rx done set with low stop under mce");
  a_overrun_keep: assert property (@(posedge clock) disable iff (!resetn)
    status_r[`UBF_ST_RX] && !stat_clr[`UBF_ST_RX] |=>
    $stable(serial_buffer))
    else $error("overrun data overwrote the buffer");
  a_irq_on_flag: assert property (@(posedge clock) disable iff (!resetn)
    (stat_set & mask_r) != 2'h0 && !(wr && off == `UBF_OFF_MASK)
    |=> irq)
    else $error("enabled flag raised no interrupt");
endmodule
`default_nettype wire

// ### ubf_params.svh
/*
  Constants of the serial port with its baud timer: register offsets,
  field positions, reset values and divider counts.
  Assumes it is included by bare name ahead of any module that uses it.
  How the pieces fit:
*/
`ifndef UBF_PARAMS_SVH
`define UBF_PARAMS_SVH
`define UBF_OFF_CTRL 8'h00
`define UBF_OFF_BUF 8'h04
`define UBF_OFF_TCFG 8'h08
`define UBF_OFF_RELOAD 8'h0C
`define UBF_OFF_STAT 8'h10
`define UBF_OFF_MASK 8'h14
`define UBF_OFF_TXCNT 8'h18
`define UBF_CTRL_FLS 7
`define UBF_CTRL_MCE 5
`define UBF_CTRL_REN 4
`define UBF_CTRL_RB8 2
`define UBF_CTRL_TDF 1
`define UBF_CTRL_RDF 0
`define UBF_ST_TX 1
`define UBF_ST_RX 0
`define UBF_TCFG_RUN 0
`define UBF_TCFG_SEL_LO 1
`define UBF_TCFG_SEL_HI 3
`define UBF_RST_RELOAD 8'h00
`define UBF_RST_SRC 3'h0
`define UBF_CNT_MAX 8'hFF
`define UBF_PRESC_LAST 6'h2F
`define UBF_OSC_DIV_LAST 3'h7
`define UBF_LAST_DATA_BIT 3'h7
`define UBF_SYNC_IDLE 3'h7
`endif

// ### ubf_pkg.sv
/*
  Types of the serial port: clock source codes, timer configuration,
  tick bundle, state encodings and the input settling function.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ubf_pkg;
  typedef enum logic [2:0] {
    UBF_SRC_SYS = 3'h0, UBF_SRC_DIV4 = 3'h1, UBF_SRC_DIV12 = 3'h2,
    UBF_SRC_DIV48 = 3'h3, UBF_SRC_OSC8 = 3'h4, UBF_SRC_PIN = 3'h5
  } ubf_clk_src_e;
  typedef struct packed {
    logic run;
    logic [2:0] src;
    logic [7:0] reload;
  } ubf_timer_cfg_s;
  typedef struct packed {
    logic tx_bit_tick;
    logic rx_sample_tick;
    logic [7:0] tx_count;
  } ubf_ticks_s;
  typedef enum logic [2:0] {
    UBF_TX_IDLE = 3'h0, UBF_TX_WAIT = 3'h1, UBF_TX_START = 3'h3,
    UBF_TX_DATA = 3'h2, UBF_TX_STOP = 3'h6
  } ubf_tx_state_e;
  typedef enum logic [1:0] {
    UBF_RX_IDLE = 2'h0, UBF_RX_START = 2'h1, UBF_RX_DATA = 2'h3,
    UBF_RX_STOP = 2'h2
  } ubf_rx_state_e;
  // a level counts once the second and third stages agree
  function automatic logic ubf_settle(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction
endpackage

// ### ubf_baud_timer.sv
/*
  Baud timer: clock source selection, the 8-bit auto-reload tx counter,
  its hidden rx copy and the divide-by-two bit tick stages.
  Assumes one system clock; external sources arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ubf_params.svh"
module ubf_baud_timer import ubf_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration and restart
  input wire ubf_timer_cfg_s cfg,
  input wire logic rx_restart,
  // asynchronous clock sources
  input wire logic ext_osc_clk,
  input wire logic timer_ext_input,
  // bit ticks
  output var ubf_ticks_s ticks
);
  logic [2:0] osc_sync_r, pin_sync_r;
  logic osc_lvl_r, pin_lvl_r, osc_lvl_nxt, pin_lvl_nxt;
  logic osc_rise, pin_rise, osc8_tick, in_tick;
  logic [5:0] presc_r;
  logic [2:0] osc8_r;
  logic [7:0] tx_cnt_r, rx_cnt_r;
  logic tx_div_r, rx_div_r, tx_ovf, rx_ovf, div12_tick;

  assign osc_lvl_nxt = ubf_settle(osc_sync_r, osc_lvl_r);
  assign pin_lvl_nxt = ubf_settle(pin_sync_r, pin_lvl_r);
  assign osc_rise = osc_lvl_nxt & ~osc_lvl_r;
  assign pin_rise = pin_lvl_nxt & ~pin_lvl_r;
  assign osc8_tick = osc_rise && (osc8_r == `UBF_OSC_DIV_LAST);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      osc_sync_r <= 3'h0;
      pin_sync_r <= 3'h0;
      osc_lvl_r <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], ext_osc_clk};
      pin_sync_r <= {pin_sync_r[1:0], timer_ext_input};
      osc_lvl_r <= osc_lvl_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // one prescaler serves /4, /12 and /48 so their ticks stay in phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      presc_r <= 6'h00;
      osc8_r <= 3'h0;
    end else begin
      presc_r <= (presc_r == `UBF_PRESC_LAST) ? 6'h00 : presc_r + 6'h01;
      if (osc_rise) begin
        osc8_r <= osc8_r + 3'h1;
      end
    end
  end

  always_comb begin
    unique case (presc_r)
      6'h0B, 6'h17, 6'h23, 6'h2F: div12_tick = 1'b1;
      default: div12_tick = 1'b0;
    endcase
  end

  always_comb begin
    unique case (cfg.src)
      UBF_SRC_SYS: in_tick = 1'b1;
      UBF_SRC_DIV4: in_tick = (presc_r[1:0] == 2'h3);
      UBF_SRC_DIV12: in_tick = div12_tick;
      UBF_SRC_DIV48: in_tick = (presc_r == `UBF_PRESC_LAST);
      UBF_SRC_OSC8: in_tick = osc8_tick;
      UBF_SRC_PIN: in_tick = pin_rise;
      default: in_tick = 1'b0;
    endcase
  end

  assign tx_ovf = cfg.run && in_tick && (tx_cnt_r == `UBF_CNT_MAX);
  assign rx_ovf = cfg.run && in_tick && (rx_cnt_r == `UBF_CNT_MAX) &&
                  !rx_restart;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_cnt_r <= 8'h00;
    end else if (cfg.run && in_tick) begin
      tx_cnt_r <= tx_ovf ? cfg.reload : tx_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_cnt_r <= 8'h00;
    end else if (rx_restart) begin
      rx_cnt_r <= cfg.reload;
    end else if (cfg.run && in_tick) begin
      rx_cnt_r <= rx_ovf ? cfg.reload : rx_cnt_r + 8'h01;
    end
  end

  // rx phase restarts at 0 so the first overflow lands mid start bit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_div_r <= 1'b0;
      rx_div_r <= 1'b0;
      ticks <= '0;
    end else begin
      if (tx_ovf) begin
        tx_div_r <= ~tx_div_r;
      end
      if (rx_restart) begin
        rx_div_r <= 1'b0;
      end else if (rx_ovf) begin
        rx_div_r <= ~rx_div_r;
      end
      ticks.tx_bit_tick <= tx_ovf & tx_div_r;
      ticks.rx_sample_tick <= rx_ovf & ~rx_div_r;
      ticks.tx_count <= tx_cnt_r;
    end
  end

  a_restart_reload: assert property (@(posedge clock) disable iff (!resetn)
    rx_restart |=> rx_cnt_r == $past(cfg.reload))
    else $error("rx counter did not reload on start");
  a_ovf_auto_reload: assert property (@(posedge clock) disable iff (!resetn)
    tx_ovf |=> tx_cnt_r == $past(cfg.reload))
    else $error("tx counter did not auto reload");
  a_tick_halved: assert property (@(posedge clock) disable iff (!resetn)
    ticks.tx_bit_tick |-> $past(tx_ovf) && !tx_div_r)
    else $error("tx bit tick not on every second overflow");
endmodule
`default_nettype wire

// ### ubf_far_end.sv
/*
  Far-end serial transceiver model: sends frames into the port and
  captures the frames that the port transmits.
  Assumes the bench sets bit_clks to the port's bit period in clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module ubf_far_end (
  // clock
  input wire logic clock,
  // serial lines
  input wire logic tx_line,
  output var logic rx_line
);
  int bit_clks = 4;
  int got_cnt = 0;
  logic [7:0] got_byte = 8'h00;
  logic got_stop = 1'b0;
  logic [7:0] sh;
  initial rx_line = 1'b1;
  // sample on the falling edge so the port's registered line has settled
  initial begin
    forever begin
      @(negedge clock iff tx_line === 1'b0);
      repeat (bit_clks / 2) @(negedge clock);
      if (tx_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_clks) @(negedge clock);
          sh[i] = tx_line;
        end
        repeat (bit_clks) @(negedge clock);
        got_stop = tx_line;
        got_byte = sh;
        got_cnt++;
      end
    end
  end
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rx_line <= f[i];
      repeat (bit_clks - 1) @(posedge clock);
    end
    @(posedge clock);
    rx_line <= 1'b1;
    repeat (bit_clks) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### ubf_uart_tb_top.sv
/*
  Self-checking bench of the serial port: register rows, transmit on all
  six timer sources, reset, receive enable, overrun and the stop check.
  Assumes the port answers APB at once and the far-end model above.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ubf_params.svh"
module ubf_uart_tb_top;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } ubf_row_s;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] tog = 2'h0;
  logic [31:0] rdq;
  logic rde;
  wire [31:0] prdata;
  wire pready, pslverr, serial_tx_pin, rx_pin, irq;
  int err_total = 0;
  int tests_run = 0;
  int cnt;
  int mult [6] = '{1, 4, 12, 48, 32, 4};
  ubf_row_s rows [9] = '{
    '{1'b0, `UBF_OFF_RELOAD, 32'h0, 32'h0, 1'b0},
    '{1'b1, `UBF_OFF_RELOAD, 32'hFE, 32'h0, 1'b0},
    '{1'b0, `UBF_OFF_RELOAD, 32'h0, 32'hFE, 1'b0},
    '{1'b1, `UBF_OFF_CTRL, 32'hB7, 32'h0, 1'b0},
    '{1'b0, `UBF_OFF_CTRL, 32'h0, 32'hB0, 1'b0},
    '{1'b1, `UBF_OFF_MASK, 32'h2, 32'h0, 1'b0},
    '{1'b0, `UBF_OFF_STAT, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h1C, 32'h5, 32'h0, 1'b1},
    '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1}
  };

  ubf_uart #(.ADDR_W(8)) dut_u (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_pin), .serial_tx_pin(serial_tx_pin),
    .ext_osc_clk(tog[1]), .timer_ext_input(tog[1]), .irq(irq));
  ubf_far_end far_u (.clock(clock), .tx_line(serial_tx_pin),
    .rx_line(rx_pin));

  initial begin
    forever #25 clock = ~clock;
  end
  // both external sources toggle at a quarter of the system clock
  always @(posedge clock) tog <= tog + 2'h1;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdq, x);
  endtask
  task automatic chk_irq(input logic x);
    @(negedge clock);
    chk({31'h0, irq}, {31'h0, x});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    tally_and_finish;
  end

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({31'h0, rde}, {31'h0, rows[i].e});
      if (!rows[i].w) chk(rdq, rows[i].x);
    end
    $display("register rows done");
    // reload FE: two timer ticks per overflow, four per bit
    for (int s = 0; s < 6; s++) begin
      far_u.bit_clks = 4 * mult[s];
      cnt = far_u.got_cnt;
      wr(`UBF_OFF_TCFG, {28'h0, s[2:0], 1'b1});
      wr(`UBF_OFF_BUF, 32'h20 + s);
      wr(`UBF_OFF_BUF, 32'h3C);
      for (int n = 0; n < 5000 && irq !== 1'b1; n++) @(negedge clock);
      chk({31'h0, serial_tx_pin}, 32'h1);
      chk(32'(far_u.got_cnt), 32'(cnt));
      repeat (13 * far_u.bit_clks) @(negedge clock);
      chk(32'(far_u.got_cnt), 32'(cnt + 1));
      chk({24'h0, far_u.got_byte}, 32'h20 + s);
      chk({31'h0, far_u.got_stop}, 32'h1);
      wr(`UBF_OFF_STAT, 32'h2);
      chk_irq(1'b0);
      $display("transmit on source %0d done", s);
    end
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk({31'h0, serial_tx_pin}, 32'h1);
    rd(`UBF_OFF_CTRL, 32'h0);
    rd(`UBF_OFF_RELOAD, 32'h0);
    $display("reset test done");
    // slower bits leave room for the input settling delay
    far_u.bit_clks = 32;
    wr(`UBF_OFF_RELOAD, 32'hF0);
    wr(`UBF_OFF_TCFG, 32'h1);
    far_u.send(8'h5A, 1'b1);
    rd(`UBF_OFF_STAT, 32'h0);
    wr(`UBF_OFF_CTRL, 32'h10);
    far_u.send(8'hC3, 1'b1);
    rd(`UBF_OFF_BUF, 32'hC3);
    rd(`UBF_OFF_CTRL, 32'h15);
    chk_irq(1'b0);
    wr(`UBF_OFF_MASK, 32'h1);
    chk_irq(1'b1);
    far_u.send(8'h11, 1'b1);
    rd(`UBF_OFF_BUF, 32'hC3);
    wr(`UBF_OFF_STAT, 32'h1);
    chk_irq(1'b0);
    wr(`UBF_OFF_CTRL, 32'h30);
    far_u.send(8'h77, 1'b0);
    rd(`UBF_OFF_BUF, 32'hC3);
    rd(`UBF_OFF_CTRL, 32'h34);
    far_u.send(8'h88, 1'b1);
    rd(`UBF_OFF_BUF, 32'h88);
    rd(`UBF_OFF_CTRL, 32'h35);
    $display("receive tests done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
